// file: core/sff_crc16.sv
// Bytewise CRC-16 engine, reflected, least significant bit first.
`timescale 1ns/1ps
module sff_crc16 (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Byte feed
  input wire logic clear,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  // Running remainder
  output logic [15:0] crc
);
  import sff_pkg::*;

  logic [15:0] next_crc;

  always_comb begin
    next_crc = crc;
    if (clear) begin
      next_crc = SFF_CRC_INIT;
    end else if (byte_valid) begin
      for (int i = 0; i < 8; i++) begin
        if (next_crc[0] ^ byte_in[i]) begin
          next_crc = (next_crc >> 1) ^ SFF_CRC_POLY;
        end else begin
          next_crc = next_crc >> 1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc <= SFF_CRC_INIT;
    end else begin
      crc <= next_crc;
    end
  end
endmodule // sff_crc16

// file: core/sff_formatter.sv
// Flexible-mode frame formatter: APB registers, buffer memory, framer and deframer.
//
// Operation
// R1 - Every accepted received frame raises the interrupt flag for software.
// R2 - Control byte goes to its register, info bytes to buffer, count recorded.
// R3 - Transmission starts on software request, no poll needed.
// R4 - Interrupt right after the closing flag, no acknowledgement awaited.
// R5 - Frame is flag, address, control, info bytes, 16-bit check, flag.
// R6 - Check sequence uses CRC-16 with terms 16, 12, 5 and 0.
// R7 - Address and control are single bytes held in their registers.
// R8 - Without control field, info follows address or flag, all stored.
// R9 - Software uses flexible mode whenever the control field is omitted.
// R10 - Address may be omitted only together with control; info follows flag.
// R11 - Mode bit means auto mode if control present, else address present; auto mode is not built, so the bit is ignored when control is present.
// R12 - Mode bits 0 and 1 select no-check and no-control; status bit 1 mode.
// R13 - Receiver keeps last 16 bits out of buffer, drops frames failing check.
// R14 - Transmitter computes the check and sends it before the closing flag.
// R15 - With no-check set, all bits to the flag are info, no check done.
// R16 - No-check option combines with every other format option.
// R17 - Opening and closing flags are 01111110.
// R18 - All fields are whole bytes; unaligned frames are dropped.
// R19 - Software sets transmit-full to send; hardware clears it after.
// R20 - Software sets receive-empty to enable; hardware clears on reception.
// R21 - Transmit control byte register fills the outgoing control field.
// R22 - Buffers never wrap; addressing ends at address 191.
// R23 - Zero inserted after five ones on send, removed on receive.
`timescale 1ns/1ps
module sff_formatter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire sff_pkg::sff_apb_req_type apb_in,
  output sff_pkg::sff_apb_rsp_type apb_out,
  // Serial link
  input wire logic serial_clk,
  input wire logic serial_rx,
  output logic serial_tx,
  // Processor interrupt
  output logic irq
);
  import sff_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sff_state_type st;
  sff_state_type next_st;
  logic [7:0] mem [0:SFF_MEM_DEPTH-1];
  logic [1:0] pins_sync;
  logic rise, fall, rx_bit, access, wr_en, mapped, mem_hit;
  logic [7:0] mem_index;
  logic [31:0] rd_value;
  logic no_check_sequence_bit, nb, addr_present, rx_buffer_empty_bit;
  logic mem_we;
  logic [7:0] mem_waddr, mem_wdata;
  logic rx_commit, rx_good, rx_store;
  logic [7:0] rx_byte, rx_store_byte;
  logic rx_crc_clear, rx_crc_valid;
  logic [15:0] rx_crc;
  logic tx_crc_clear, tx_crc_valid;
  logic [7:0] tx_crc_byte;
  logic [15:0] tx_crc;
  logic tx_info_avail;
  logic [8:0] tx_mem_addr, rx_mem_addr;
  sff_tx_type tx_info_or_after, tx_after;
  logic [7:0] tx_after_byte;

  sff_sync2 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({serial_rx, serial_clk}),
    .q(pins_sync)
  );

  sff_crc16 u_rx_crc (
    .pclk(pclk),
    .presetn(presetn),
    .clear(rx_crc_clear),
    .byte_valid(rx_crc_valid),
    .byte_in(rx_byte),
    .crc(rx_crc)
  );

  sff_crc16 u_tx_crc (
    .pclk(pclk),
    .presetn(presetn),
    .clear(tx_crc_clear),
    .byte_valid(tx_crc_valid),
    .byte_in(tx_crc_byte),
    .crc(tx_crc)
  );

  // ----------------------------------------------------------------
  // Mode decode, edges and APB decode
  // ----------------------------------------------------------------
  assign no_check_sequence_bit = st.mode[SFF_MODE_NO_CHECK_SEQUENCE_BIT]; // R12
  assign nb = st.mode[SFF_MODE_NB]; // R12
  assign addr_present = !nb || st.status[SFF_ST_AM]; // R10 R11
  assign rx_buffer_empty_bit = st.status[SFF_ST_RBE];
  assign rise = pins_sync[0] && !st.sclk_prev;
  assign fall = !pins_sync[0] && st.sclk_prev;
  assign rx_bit = pins_sync[1];
  assign access = apb_in.psel && apb_in.penable;
  assign mem_hit = (apb_in.paddr[11:10] == SFF_MEM_REGION) &&
                   (apb_in.paddr[9:2] < 8'(SFF_MEM_DEPTH));
  assign mem_index = apb_in.paddr[9:2];
  assign wr_en = access && apb_in.pwrite;
  assign apb_out = '{prdata: st.prdata, pready: access, pslverr: access && !mapped};
  assign irq = st.status[SFF_ST_SI];
  assign serial_tx = !st.tx_space;

  always_comb begin
    mapped = 1'b1;
    rd_value = 32'h0;
    if (mem_hit) begin
      rd_value = {24'h0, mem[mem_index]};
    end else begin
      case (apb_in.paddr)
        SFF_OFF_MODE: rd_value = {24'h0, st.mode};
        SFF_OFF_STATUS: rd_value = {24'h0, st.status};
        SFF_OFF_STATION_ADDRESS_REG: rd_value = {24'h0, st.station_address_reg};
        SFF_OFF_TCB: rd_value = {24'h0, st.tx_control_byte_reg};
        SFF_OFF_RCB: rd_value = {24'h0, st.rx_control_byte_reg};
        SFF_OFF_RBS: rd_value = {24'h0, st.rx_buffer_start_reg};
        SFF_OFF_RBL: rd_value = {24'h0, st.rbl};
        SFF_OFF_RFL: rd_value = {24'h0, st.rx_field_length_reg};
        SFF_OFF_TBS: rd_value = {24'h0, st.tbs};
        SFF_OFF_TBL: rd_value = {24'h0, st.tbl};
        default: mapped = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit byte sequencing
  // ----------------------------------------------------------------
  assign tx_mem_addr = {1'b0, st.tbs} + {1'b0, st.tx_idx};
  assign tx_info_avail = (st.tx_idx < st.tbl) && (tx_mem_addr <= SFF_BUF_END); // R22
  assign tx_info_or_after = tx_info_avail ? TX_INFO : (!no_check_sequence_bit ? TX_FCS_LO : TX_CLOSE); // R14 R15 R16

  always_comb begin
    case (st.tx_state)
      TX_OPEN: tx_after = addr_present ? TX_ADDR : tx_info_or_after; // R10
      TX_ADDR: tx_after = !nb ? TX_CTRL : tx_info_or_after; // R8
      TX_CTRL: tx_after = tx_info_or_after;
      TX_INFO: tx_after = tx_info_or_after;
      TX_FCS_LO: tx_after = TX_FCS_HI; // R5
      TX_FCS_HI: tx_after = TX_CLOSE;
      default: tx_after = TX_IDLE;
    endcase
    case (tx_after)
      TX_ADDR: tx_after_byte = st.station_address_reg; // R7
      TX_CTRL: tx_after_byte = st.tx_control_byte_reg; // R21
      TX_INFO: tx_after_byte = mem[tx_mem_addr[7:0]];
      TX_FCS_LO: tx_after_byte = ~tx_crc[7:0]; // R14
      TX_FCS_HI: tx_after_byte = st.tx_fcs[15:8]; // R14
      default: tx_after_byte = SFF_FLAG; // R17
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign rx_byte = {rx_bit, st.rx_shift[7:1]};
  assign rx_mem_addr = {1'b0, st.rx_buffer_start_reg} + {1'b0, st.rx_count};
  assign rx_good = (st.rx_state == RX_FRAME) && (st.rx_bitcnt == SFF_LAST_BIT) && // R18
                   st.rx_any && (st.rx_field == FLD_INFO) && !st.rx_drop && rx_buffer_empty_bit &&
                   (no_check_sequence_bit || ((st.rx_held == SFF_FCS_BYTES) && (rx_crc == SFF_CRC_GOOD))); // R13

  always_comb begin
    next_st = st;
    next_st.sclk_prev = pins_sync[0];
    mem_we = 1'b0;
    rx_store_byte = rx_byte;
    mem_waddr = rx_mem_addr[7:0];
    mem_wdata = rx_byte;
    rx_commit = 1'b0;
    rx_store = 1'b0;
    rx_crc_clear = 1'b0;
    rx_crc_valid = 1'b0;
    tx_crc_clear = 1'b0;
    tx_crc_valid = 1'b0;
    tx_crc_byte = tx_after_byte;
    if (apb_in.psel && !apb_in.penable) begin
      next_st.prdata = rd_value;
    end
    if (wr_en && mapped) begin
      if (mem_hit) begin
        mem_we = 1'b1;
        mem_waddr = mem_index;
        mem_wdata = apb_in.pwdata[7:0];
      end else begin
        case (apb_in.paddr)
          SFF_OFF_MODE: next_st.mode = apb_in.pwdata[7:0];
          SFF_OFF_STATUS: next_st.status = apb_in.pwdata[7:0]; // R19 R20
          SFF_OFF_STATION_ADDRESS_REG: next_st.station_address_reg = apb_in.pwdata[7:0];
          SFF_OFF_TCB: next_st.tx_control_byte_reg = apb_in.pwdata[7:0];
          SFF_OFF_RCB: next_st.rx_control_byte_reg = apb_in.pwdata[7:0];
          SFF_OFF_RBS: next_st.rx_buffer_start_reg = apb_in.pwdata[7:0];
          SFF_OFF_RBL: next_st.rbl = apb_in.pwdata[7:0];
          SFF_OFF_RFL: next_st.rx_field_length_reg = apb_in.pwdata[7:0];
          SFF_OFF_TBS: next_st.tbs = apb_in.pwdata[7:0];
          SFF_OFF_TBL: next_st.tbl = apb_in.pwdata[7:0];
          default: next_st.mode = st.mode;
        endcase
      end
    end

    // Receive path: one line bit per rising serial clock edge.
    if (rise) begin
      next_st.rx_raw = {rx_bit, st.rx_raw[7:1]};
      next_st.rx_ones = rx_bit ? ((st.rx_ones == SFF_LAST_BIT) ? st.rx_ones :
                                  st.rx_ones + 3'h1) : 3'h0;
      if (rx_bit && (st.rx_ones == SFF_ABORT_ONES)) begin
        next_st.rx_state = RX_HUNT;
      end else if ({rx_bit, st.rx_raw[7:1]} == SFF_FLAG) begin // R17
        if (rx_good) begin
          rx_commit = 1'b1;
          next_st.rx_field_length_reg = st.rx_count; // R2
          if (!nb) begin
            next_st.rx_control_byte_reg = st.rx_ctrl; // R2 R7 R8
          end
          next_st.status[SFF_ST_RBE] = 1'b0; // R20
          next_st.status[SFF_ST_SI] = 1'b1; // R1
        end
        next_st.rx_state = RX_FRAME;
        next_st.rx_bitcnt = 3'h0;
        next_st.rx_field = addr_present ? FLD_ADDR : FLD_INFO; // R10 R11
        next_st.rx_held = 2'h0;
        next_st.rx_count = 8'h0;
        next_st.rx_drop = 1'b0;
        next_st.rx_any = 1'b0;
        rx_crc_clear = 1'b1;
      end else if ((st.rx_state == RX_FRAME) &&
                   !(!rx_bit && (st.rx_ones == SFF_STUFF_ONES))) begin // R23
        next_st.rx_shift = rx_byte;
        next_st.rx_bitcnt = st.rx_bitcnt + 3'h1;
        if (st.rx_bitcnt == SFF_LAST_BIT) begin // R18
          next_st.rx_any = 1'b1;
          rx_crc_valid = 1'b1; // R6
          case (st.rx_field)
            FLD_ADDR: begin
              if ((rx_byte != st.station_address_reg) && (rx_byte != SFF_BROADCAST)) begin // R7
                next_st.rx_drop = 1'b1;
              end
              next_st.rx_field = nb ? FLD_INFO : FLD_CTRL; // R8
            end
            FLD_CTRL: begin
              next_st.rx_ctrl = rx_byte;
              next_st.rx_field = FLD_INFO;
            end
            default: begin
              if (no_check_sequence_bit) begin
                rx_store = 1'b1; // R15
              end else begin
                rx_store = (st.rx_held == SFF_FCS_BYTES); // R13
                rx_store_byte = st.rx_hold0;
                next_st.rx_hold0 = st.rx_hold1;
                next_st.rx_hold1 = rx_byte;
                if (st.rx_held != SFF_FCS_BYTES) begin
                  next_st.rx_held = st.rx_held + 2'h1;
                end
              end
            end
          endcase
        end
      end
    end
    if (rx_store && rx_buffer_empty_bit && !st.rx_drop) begin
      if ((st.rx_count < st.rbl) && (rx_mem_addr <= SFF_BUF_END)) begin // R22
        mem_we = 1'b1;
        mem_waddr = rx_mem_addr[7:0];
        mem_wdata = rx_store_byte;
        next_st.rx_count = st.rx_count + 8'h1;
      end else begin
        next_st.status[SFF_ST_BOV] = 1'b1;
      end
    end

    // Transmit path: one line bit per falling serial clock edge.
    if (st.tx_state == TX_IDLE) begin
      if (fall) begin
        next_st.tx_space = 1'b0;
      end
      if (st.status[SFF_ST_TBF] && st.status[SFF_ST_RTS]) begin // R3 R19
        next_st.tx_state = TX_OPEN;
        next_st.tx_shift = SFF_FLAG; // R17
        next_st.tx_bitcnt = 3'h0;
        next_st.tx_ones = 3'h0;
        next_st.tx_idx = 8'h0;
        tx_crc_clear = 1'b1;
      end
    end else if (fall) begin
      if (st.tx_ones == SFF_STUFF_ONES) begin
        next_st.tx_space = 1'b1; // R23
        next_st.tx_ones = 3'h0;
      end else begin
        next_st.tx_space = !st.tx_shift[0];
        next_st.tx_ones = (st.tx_shift[0] && (st.tx_state != TX_OPEN) &&
                           (st.tx_state != TX_CLOSE)) ? st.tx_ones + 3'h1 : 3'h0;
        next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
        next_st.tx_bitcnt = st.tx_bitcnt + 3'h1;
        if (st.tx_bitcnt == SFF_LAST_BIT) begin // R18
          next_st.tx_state = tx_after;
          next_st.tx_shift = tx_after_byte;
          tx_crc_valid = (tx_after == TX_ADDR) || (tx_after == TX_CTRL) ||
                         (tx_after == TX_INFO); // R6
          if (tx_after == TX_INFO) begin
            next_st.tx_idx = st.tx_idx + 8'h1;
          end
          if (tx_after == TX_FCS_LO) begin
            next_st.tx_fcs = ~tx_crc;
          end
          if (tx_after == TX_IDLE) begin
            next_st.status[SFF_ST_TBF] = 1'b0; // R19
            next_st.status[SFF_ST_RTS] = 1'b0;
            next_st.status[SFF_ST_SI] = 1'b1; // R4
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State and buffer memory
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= SFF_STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rx_irq;
    rx_commit |=> irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("no interrupt after frame received"); // R1

  property p_rx_length;
    rx_commit |=> (st.rx_field_length_reg == $past(st.rx_count)) && !rx_buffer_empty_bit;
  endproperty
  a_rx_length: assert property (p_rx_length) else $error("length or enable wrong"); // R2 R20

  property p_rx_check;
    rx_commit && !no_check_sequence_bit |-> (rx_crc == SFF_CRC_GOOD) && (st.rx_held == SFF_FCS_BYTES);
  endproperty
  a_rx_check: assert property (p_rx_check) else $error("frame accepted with bad check"); // R13

  property p_start;
    (st.tx_state == TX_IDLE) && st.status[SFF_ST_TBF] && st.status[SFF_ST_RTS]
      |=> (st.tx_state == TX_OPEN) && (st.tx_shift == SFF_FLAG) && (st.tx_bitcnt == 3'h0);
  endproperty
  a_start: assert property (p_start) else $error("transmit did not start"); // R3

  property p_tx_done;
    (st.tx_state == TX_CLOSE) && fall && (st.tx_bitcnt == SFF_LAST_BIT) &&
      (st.tx_ones != SFF_STUFF_ONES) |=> irq && !st.status[SFF_ST_TBF] ##1 irq;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("no interrupt after transmit"); // R4

  property p_fcs_only;
    (st.tx_state == TX_FCS_LO) |-> !no_check_sequence_bit;
  endproperty
  a_fcs_only: assert property (p_fcs_only) else $error("check sent with no-check set"); // R15

  property p_no_ctrl;
    (st.rx_field == FLD_CTRL) || (st.tx_state == TX_CTRL) |-> !nb;
  endproperty
  a_no_ctrl: assert property (p_no_ctrl) else $error("control field with no-control set"); // R8

  property p_buf_end;
    mem_we |-> ({1'b0, mem_waddr} <= SFF_BUF_END);
  endproperty
  a_buf_end: assert property (p_buf_end) else $error("buffer written past its end"); // R22

  property p_stuff;
    (st.tx_state != TX_IDLE) && fall && (st.tx_ones == SFF_STUFF_ONES) |=> !serial_tx;
  endproperty
  a_stuff: assert property (p_stuff) else $error("zero not inserted after five ones"); // R23

endmodule // sff_formatter

// file: core/sff_pkg.sv
// Shared constants and types of the flexible frame formatter.
package sff_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB and the buffer memory window
  // ----------------------------------------------------------------
  localparam logic [11:0] SFF_OFF_MODE = 12'h000;
  localparam logic [11:0] SFF_OFF_STATUS = 12'h004;
  localparam logic [11:0] SFF_OFF_STATION_ADDRESS_REG = 12'h008;
  localparam logic [11:0] SFF_OFF_TCB = 12'h00C;
  localparam logic [11:0] SFF_OFF_RCB = 12'h010;
  localparam logic [11:0] SFF_OFF_RBS = 12'h014;
  localparam logic [11:0] SFF_OFF_RBL = 12'h018;
  localparam logic [11:0] SFF_OFF_RFL = 12'h01C;
  localparam logic [11:0] SFF_OFF_TBS = 12'h020;
  localparam logic [11:0] SFF_OFF_TBL = 12'h024;
  localparam logic [1:0] SFF_MEM_REGION = 2'h1;
  localparam int SFF_MEM_DEPTH = 192;

  // ----------------------------------------------------------------
  // Field positions, reset value and line constants
  // ----------------------------------------------------------------
  localparam int SFF_MODE_NO_CHECK_SEQUENCE_BIT = 0;
  localparam int SFF_MODE_NB = 1;
  localparam int SFF_ST_AM = 1;
  localparam int SFF_ST_BOV = 3;
  localparam int SFF_ST_SI = 4;
  localparam int SFF_ST_RTS = 5;
  localparam int SFF_ST_RBE = 6;
  localparam int SFF_ST_TBF = 7;
  localparam logic [7:0] SFF_FLAG = 8'h7E;
  localparam logic [7:0] SFF_BROADCAST = 8'hFF;
  localparam logic [8:0] SFF_BUF_END = 9'h0BF;
  localparam logic [15:0] SFF_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] SFF_CRC_POLY = 16'h8408;
  localparam logic [15:0] SFF_CRC_GOOD = 16'hF0B8;
  localparam logic [2:0] SFF_STUFF_ONES = 3'h5;
  localparam logic [2:0] SFF_ABORT_ONES = 3'h6;
  localparam logic [2:0] SFF_LAST_BIT = 3'h7;
  localparam logic [1:0] SFF_FCS_BYTES = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sff_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sff_apb_rsp_type;

  typedef enum logic [0:0] {RX_HUNT, RX_FRAME} sff_rx_type;
  typedef enum logic [1:0] {FLD_ADDR, FLD_CTRL, FLD_INFO} sff_field_type;
  typedef enum logic [2:0] {
    TX_IDLE, TX_OPEN, TX_ADDR, TX_CTRL, TX_INFO, TX_FCS_LO, TX_FCS_HI, TX_CLOSE
  } sff_tx_type;

  typedef struct packed {
    logic [7:0] mode, status, station_address_reg, tx_control_byte_reg, rx_control_byte_reg, rx_buffer_start_reg, rbl, rx_field_length_reg, tbs, tbl;
    logic [31:0] prdata;
    logic sclk_prev;
    sff_rx_type rx_state;
    logic [7:0] rx_raw;
    logic [2:0] rx_ones;
    logic [7:0] rx_shift;
    logic [2:0] rx_bitcnt;
    sff_field_type rx_field;
    logic [7:0] rx_hold0, rx_hold1;
    logic [1:0] rx_held;
    logic [7:0] rx_count, rx_ctrl;
    logic rx_drop, rx_any;
    sff_tx_type tx_state;
    logic [7:0] tx_shift;
    logic [2:0] tx_bitcnt, tx_ones;
    logic [7:0] tx_idx;
    logic [15:0] tx_fcs;
    logic tx_space;
  } sff_state_type;

  localparam sff_state_type SFF_STATE_RESET = '0;

endpackage

// file: core/sff_sync2.sv
// Two-flop synchroniser for the serial clock and receive data pins.
`timescale 1ns/1ps
module sff_sync2 (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins in, synchronised levels out
  input wire logic [1:0] d,
  output logic [1:0] q
);
  logic [1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 2'h0;
      q <= 2'h0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sff_sync2

// file: test/sff_formatter_test.sv
// Self-checking bench of the flexible frame formatter against a remote station model.
`timescale 1ns/1ps
module sff_formatter_test;
  import sff_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  sff_apb_req_type req = '0;
  sff_apb_rsp_type rsp;
  logic serial_clk, serial_rx, serial_tx, irq;
  logic [31:0] rdv;
  logic erv;
  int mismatches = 0;
  int checks_done = 0;
  always #5 pclk = ~pclk;
  sff_formatter dut (.pclk(pclk), .presetn(presetn), .apb_in(req), .apb_out(rsp),
    .serial_clk(serial_clk), .serial_rx(serial_rx), .serial_tx(serial_tx), .irq(irq));
  sff_remote_station rs (.serial_clk(serial_clk), .serial_rx(serial_rx), .serial_tx(serial_tx));
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_frame(input logic [7:0] g[$], input logic [7:0] e[$]);
    bit bad;
    bad = g.size() != e.size();
    foreach (e[i]) if (i < g.size() && g[i] !== e[i]) bad = 1;
    chk({31'h0, bad}, 32'h0, "frame");
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h000000, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rdv = rsp.prdata;
    erv = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1) begin
      chk(0, 1, "apb timeout");
      wrap_up();
    end
  endtask
  function automatic logic [11:0] ma(input int i);
    return 12'h400 + 12'(i * 4);
  endfunction
  task automatic run_mode(input logic no_check_sequence_bit, input logic nb, input logic am, input logic bad);
    logic [7:0] station_address_reg, tx_control_byte_reg, tbs, tbl, ctrl, rx_buffer_start_reg, st;
    logic [7:0] exp[$], fr[$], info[$];
    logic [15:0] c;
    int n;
    station_address_reg = 8'($urandom());
    tx_control_byte_reg = 8'($urandom());
    ctrl = 8'($urandom());
    tbs = 8'(186 + $urandom_range(0, 3));
    tbl = 8'($urandom_range(1, 5));
    rx_buffer_start_reg = 8'($urandom_range(0, 100));
    st = {6'h00, am, 1'b0};
    wr_all(nb, no_check_sequence_bit, station_address_reg, tx_control_byte_reg, tbs, tbl, rx_buffer_start_reg);
    if (!nb || am) exp.push_back(station_address_reg);
    if (!nb) exp.push_back(tx_control_byte_reg);
    for (int i = tbs; i < tbs + tbl && i < 192; i++) begin
      exp.push_back(8'($urandom()));
      apb(1, ma(i), exp[$]);
    end
    c = rs.fcs(exp);
    if (!no_check_sequence_bit) exp = {exp, c[7:0], c[15:8]};
    rs.got.delete();
    if (!bad) apb(1, SFF_OFF_STATUS, 8'hA0 | st);
    for (n = 0; n < 600 && irq !== 1'b1 && !bad; n++) rs.run(1);
    rs.run(4);
    if (!bad) chk_frame(rs.got, exp);
    apb(0, SFF_OFF_STATUS, 0);
    chk(rdv, {24'h0, bad ? st : 8'h10 | st}, "tx status");
    if (irq !== 1'b1 && !bad) wrap_up();
    apb(1, SFF_OFF_STATUS, 8'h40 | st);
    info = {8'hFF, 8'($urandom())};
    repeat ($urandom_range(0, 2)) info.push_back(8'($urandom()));
    if (!nb || am) fr.push_back(station_address_reg);
    if (!nb) fr.push_back(ctrl);
    fr = {fr, info};
    rs.send(fr, !no_check_sequence_bit, bad);
    rs.run(rs.tq.size() + 2);
    repeat (10) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, !bad}, "rx irq");
    apb(0, SFF_OFF_STATUS, 0);
    chk(rdv, {24'h0, bad ? 8'h40 | st : 8'h10 | st}, "rx status");
    apb(0, SFF_OFF_RFL, 0);
    if (!bad) chk(rdv, 32'(info.size()), "rx length");
    apb(0, SFF_OFF_RCB, 0);
    if (!nb && !bad) chk(rdv, {24'h0, ctrl}, "rx control");
    foreach (info[i]) begin
      apb(0, ma(rx_buffer_start_reg + i), 0);
      if (!bad) chk(rdv, {24'h0, info[i]}, "rx data");
    end
    apb(1, SFF_OFF_STATUS, 0);
    $display("Test no_check_sequence_bit %0d nb %0d am %0d bad %0d done", no_check_sequence_bit, nb, am, bad);
  endtask
  task automatic wr_all(input logic nb, input logic no_check_sequence_bit, input logic [7:0] s, t, tb, tl, rb);
    apb(1, SFF_OFF_MODE, {6'h00, nb, no_check_sequence_bit});
    apb(1, SFF_OFF_STATION_ADDRESS_REG, s);
    apb(1, SFF_OFF_TCB, t);
    apb(1, SFF_OFF_TBS, tb);
    apb(1, SFF_OFF_TBL, tl);
    apb(1, SFF_OFF_RBS, rb);
    apb(1, SFF_OFF_RBL, 8'h08);
  endtask
  initial begin
    void'($urandom(32'h544D));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, SFF_OFF_STATUS, 0);
    chk(rdv, 32'h0, "status reset");
    apb(0, 12'h028, 0);
    chk({31'h0, erv}, 32'h1, "unmapped");
    for (int m = 0; m < 9; m++) begin
      run_mode(m[0], m[1], m[2], m[3]);
    end
    wrap_up();
  end
endmodule // sff_formatter_test

// file: test/sff_remote_station.sv
// Remote link station that clocks the link, sends frames and captures transmitted frames.
`timescale 1ns/1ps
module sff_remote_station (
  // Link pins
  output logic serial_clk,
  output logic serial_rx,
  input wire logic serial_tx
);
  logic [7:0] win = 8'h00;
  logic [7:0] v;
  int ones = 0;
  int sones = 0;
  bit prev = 0;
  bit tq[$];
  bit bq[$];
  logic [7:0] got[$];
  initial begin
    serial_clk = 1'b0;
    serial_rx = 1'b1;
  end
  function automatic logic [15:0] fcs(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? 16'h8408 : 16'h0);
    return ~c;
  endfunction
  task automatic put_byte(input logic [7:0] b, input bit stuff);
    for (int k = 0; k < 8; k++) begin
      tq.push_back(b[k]);
      sones = b[k] ? sones + 1 : 0;
      if (stuff && sones == 5) begin
        tq.push_back(1'b0);
        sones = 0;
      end
    end
    if (!stuff) sones = 0;
  endtask
  task automatic send(input logic [7:0] q[$], input bit crc_on, input bit bad);
    logic [15:0] c;
    c = fcs(q) ^ {15'h0, bad};
    put_byte(8'h7E, 0);
    foreach (q[i]) put_byte(q[i], 1);
    if (crc_on) begin
      put_byte(c[7:0], 1);
      put_byte(c[15:8], 1);
    end
    put_byte(8'h7E, 0);
  endtask
  // The link clock only runs while this task is called, and idle line is mark.
  // Pins change a few ns off the bench clock edges so the synchroniser never races them.
  task automatic run(input int n);
    repeat (n) begin
      #2 serial_rx = (tq.size() > 0) ? tq.pop_front() : 1'b1;
      #100 serial_clk = 1'b1;
      #96 serial_clk = 1'b0;
      #2;
    end
  endtask
  always @(posedge serial_clk) begin
    win = {serial_tx, win[7:1]};
    if (!(ones == 5 && serial_tx == 1'b0)) bq.push_back(serial_tx);
    ones = serial_tx ? ones + 1 : 0;
    if (ones >= 7) prev = 0;
    if (win == 8'h7E) begin
      if (prev && bq.size() > 8 && bq.size() % 8 == 0) begin
        got.delete();
        for (int i = 0; i + 8 < bq.size(); i += 8) begin
          for (int k = 0; k < 8; k++) v[k] = bq[i+k];
          got.push_back(v);
        end
      end
      bq.delete();
      prev = 1;
    end
  end
endmodule // sff_remote_station
